// ==== src/timer16_counter_input_capture.sv ====
module timer16_counter_input_capture (
  input  wire logic                  i_clock,
  input  wire logic                  i_rstn,
  input  wire timer16_pkg::bus_req_t i_bus,
  output logic [7:0]                 o_rdata,
  input  wire logic [3:0]            i_prescale_tick,
  input  wire logic                  i_external_clock_pin,
  input  wire logic                  i_capture_pin,
  input  wire logic                  i_comparator_output,
  input  wire logic [15:0]           i_compare_a_top,
  input  wire logic                  i_capture_irq_ack,
  input  wire logic                  i_overflow_irq_ack,
  output logic [15:0]                o_count_value,
  output logic                       o_count_floor,
  output logic                       o_count_top,
  output logic [3:0]                 o_waveform_mode_field,
  output logic                       o_capture_irq,
  output logic                       o_overflow_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: capture pin, comparator output, external clock pin.

  logic [2:0] sync1;
  logic [2:0] sync2;
  logic       ext_prev;
  logic [2:0] next_sync1;
  logic [2:0] next_sync2;
  logic       next_ext_prev;

  // Both triggers share the external clock's two-stage scheme.
  always_comb begin
    next_sync1    = {i_capture_pin, i_comparator_output, i_external_clock_pin};
    next_sync2    = sync1;
    next_ext_prev = sync2[0];
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1    <= 3'h0;
      sync2    <= 3'h0;
      ext_prev <= 1'b0;
    end else begin
      sync1    <= next_sync1;
      sync2    <= next_sync2;
      ext_prev <= next_ext_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and counter state.

  logic [7:0]                control_a;
  timer16_pkg::control_b_t   control_b;
  logic [7:0]                comparator_control;
  logic [15:0]               count_value;
  logic                      count_down;
  logic [15:0]               capture_value;
  logic [7:0]                holding;
  logic                      capture_flag;
  logic                      overflow_flag;
  logic                      capture_irq_enable;
  logic                      overflow_irq_enable;
  logic [3:0]                samples;
  logic                      filtered;
  logic                      filtered_prev;
  logic [7:0]                rdata;

  logic [7:0]                next_control_a;
  timer16_pkg::control_b_t   next_control_b;
  logic [7:0]                next_comparator_control;
  logic [15:0]               next_count_value;
  logic                      next_count_down;
  logic [15:0]               next_capture_value;
  logic [7:0]                next_holding;
  logic                      next_capture_flag;
  logic                      next_overflow_flag;
  logic                      next_capture_irq_enable;
  logic                      next_overflow_irq_enable;
  logic [3:0]                next_samples;
  logic                      next_filtered;
  logic                      next_filtered_prev;
  logic [7:0]                next_rdata;

  logic [3:0]                mode;
  logic [15:0]               top;
  logic                      timer_tick;
  logic                      trigger;
  logic                      capture_active;
  logic                      capture_event;
  logic                      overflow_event;
  logic                      wr_count_low;
  logic                      wr_capture_low;

  // The mode field is split across both control registers.
  assign mode           = {control_b.mode_high, control_a[1:0]};
  assign top            = timer16_pkg::mode_top(mode, capture_value, i_compare_a_top);
  assign capture_active = !timer16_pkg::uses_capture_top(mode);
  // Swapping the source can look like an edge, so software clears the flag afterwards.
  assign trigger        = comparator_control[timer16_pkg::COMPARATOR_SEL_BIT] ? sync2[1] : sync2[2];
  assign wr_count_low   = i_bus.wr && (i_bus.addr == timer16_pkg::ADDR_COUNT_VALUE_LOW);
  assign wr_capture_low = i_bus.wr && (i_bus.addr == timer16_pkg::ADDR_CAPTURE_VALUE_LOW)
                          && timer16_pkg::uses_capture_top(mode);

  // Tick source; prescaler taps arrive already on this clock.
  always_comb begin
    unique case (control_b.clock_source_field)
      3'h0:    timer_tick = 1'b0;
      3'h1:    timer_tick = 1'b1;
      3'h2:    timer_tick = i_prescale_tick[0];
      3'h3:    timer_tick = i_prescale_tick[1];
      3'h4:    timer_tick = i_prescale_tick[2];
      3'h5:    timer_tick = i_prescale_tick[3];
      3'h6:    timer_tick = ext_prev & ~sync2[0];
      3'h7:    timer_tick = ~ext_prev & sync2[0];
    endcase
  end

  // Filter and edge detector; the filter costs four clocks of latency.
  always_comb begin
    next_samples       = {samples[2:0], trigger};
    next_filtered_prev = filtered;
    if (control_b.noise_filter_enable) begin
      if (&samples) begin
        next_filtered = 1'b1;
      end else if (~|samples) begin
        next_filtered = 1'b0;
      end else begin
        next_filtered = filtered;
      end
    end else begin
      next_filtered = trigger;
    end
    capture_event = capture_active && (control_b.rising_edge ? (filtered & ~filtered_prev)
                                                             : (~filtered & filtered_prev));
  end

  // Counter sequencing, software access and flags.
  always_comb begin
    next_control_a           = control_a;
    next_control_b           = control_b;
    next_comparator_control  = comparator_control;
    next_count_value         = count_value;
    next_count_down          = count_down;
    next_capture_value       = capture_value;
    next_holding             = holding;
    next_capture_irq_enable  = capture_irq_enable;
    next_overflow_irq_enable = overflow_irq_enable;
    next_rdata               = 8'h00;
    overflow_event           = 1'b0;
    if (timer_tick) begin
      if (timer16_pkg::dual_slope(mode)) begin
        if (!count_down && (count_value >= top)) begin
          next_count_down  = 1'b1;
          next_count_value = count_value - timer16_pkg::COUNT_ONE;
        end else if (count_down && (count_value == timer16_pkg::COUNT_FLOOR)) begin
          next_count_down  = 1'b0;
          next_count_value = count_value + timer16_pkg::COUNT_ONE;
          overflow_event   = 1'b1;
        end else if (count_down) begin
          next_count_value = count_value - timer16_pkg::COUNT_ONE;
        end else begin
          next_count_value = count_value + timer16_pkg::COUNT_ONE;
        end
      end else begin
        next_count_down = 1'b0;
        if (count_value == top) begin
          next_count_value = timer16_pkg::COUNT_FLOOR;
          overflow_event   = timer16_pkg::overflow_at_top(mode) || (count_value == timer16_pkg::COUNT_MAX);
        end else begin
          next_count_value = count_value + timer16_pkg::COUNT_ONE;
          overflow_event   = (count_value == timer16_pkg::COUNT_MAX);
        end
      end
    end
    if (capture_event) begin
      next_capture_value = count_value;
    end
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        timer16_pkg::ADDR_CONTROL_A:          next_rdata = control_a;
        timer16_pkg::ADDR_CONTROL_B:          next_rdata = control_b;
        timer16_pkg::ADDR_COUNT_VALUE_LOW: begin
          next_rdata   = count_value[7:0];
          next_holding = count_value[15:8];
        end
        timer16_pkg::ADDR_CAPTURE_VALUE_LOW: begin
          next_rdata   = capture_value[7:0];
          next_holding = capture_value[15:8];
        end
        timer16_pkg::ADDR_COUNT_VALUE_HIGH,
        timer16_pkg::ADDR_CAPTURE_VALUE_HIGH: next_rdata = holding;
        timer16_pkg::ADDR_FLAGS: begin
          next_rdata[timer16_pkg::FLAG_OVERFLOW_BIT] = overflow_flag;
          next_rdata[timer16_pkg::FLAG_CAPTURE_BIT]  = capture_flag;
        end
        timer16_pkg::ADDR_IRQ_ENABLE: begin
          next_rdata[timer16_pkg::FLAG_OVERFLOW_BIT] = overflow_irq_enable;
          next_rdata[timer16_pkg::FLAG_CAPTURE_BIT]  = capture_irq_enable;
        end
        timer16_pkg::ADDR_COMPARATOR_CONTROL: next_rdata = comparator_control;
        default:                              next_rdata = 8'h00;
      endcase
    end
    if (i_bus.wr) begin
      unique case (i_bus.addr)
        timer16_pkg::ADDR_CONTROL_A:          next_control_a = i_bus.wdata;
        timer16_pkg::ADDR_CONTROL_B:          next_control_b = i_bus.wdata;
        timer16_pkg::ADDR_COUNT_VALUE_HIGH,
        timer16_pkg::ADDR_CAPTURE_VALUE_HIGH: next_holding = i_bus.wdata;
        timer16_pkg::ADDR_IRQ_ENABLE: begin
          next_overflow_irq_enable = i_bus.wdata[timer16_pkg::FLAG_OVERFLOW_BIT];
          next_capture_irq_enable  = i_bus.wdata[timer16_pkg::FLAG_CAPTURE_BIT];
        end
        timer16_pkg::ADDR_COMPARATOR_CONTROL: next_comparator_control = i_bus.wdata;
        default:                              next_holding = holding;
      endcase
    end
    // A software write lands last so it beats any count or clear.
    if (wr_count_low) begin
      next_count_value = {holding, i_bus.wdata};
    end
    if (wr_capture_low) begin
      next_capture_value = {holding, i_bus.wdata};
    end
    // Set beats clear; a new event is never lost to a clear.
    next_capture_flag = capture_event
      || (capture_flag && !i_capture_irq_ack
          && !(i_bus.wr && (i_bus.addr == timer16_pkg::ADDR_FLAGS)
               && i_bus.wdata[timer16_pkg::FLAG_CAPTURE_BIT]));
    next_overflow_flag = overflow_event
      || (overflow_flag && !i_overflow_irq_ack
          && !(i_bus.wr && (i_bus.addr == timer16_pkg::ADDR_FLAGS)
               && i_bus.wdata[timer16_pkg::FLAG_OVERFLOW_BIT]));
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      control_a           <= timer16_pkg::BYTE_RESET;
      control_b           <= timer16_pkg::BYTE_RESET;
      comparator_control  <= timer16_pkg::BYTE_RESET;
      count_value         <= timer16_pkg::COUNT_FLOOR;
      count_down          <= 1'b0;
      capture_value       <= timer16_pkg::COUNT_FLOOR;
      holding             <= timer16_pkg::BYTE_RESET;
      capture_flag        <= 1'b0;
      overflow_flag       <= 1'b0;
      capture_irq_enable  <= 1'b0;
      overflow_irq_enable <= 1'b0;
      samples             <= 4'h0;
      filtered            <= 1'b0;
      filtered_prev       <= 1'b0;
      rdata               <= timer16_pkg::BYTE_RESET;
    end else begin
      control_a           <= next_control_a;
      control_b           <= next_control_b;
      comparator_control  <= next_comparator_control;
      count_value         <= next_count_value;
      count_down          <= next_count_down;
      capture_value       <= next_capture_value;
      holding             <= next_holding;
      capture_flag        <= next_capture_flag;
      overflow_flag       <= next_overflow_flag;
      capture_irq_enable  <= next_capture_irq_enable;
      overflow_irq_enable <= next_overflow_irq_enable;
      samples             <= next_samples;
      filtered            <= next_filtered;
      filtered_prev       <= next_filtered_prev;
      rdata               <= next_rdata;
    end
  end

  // Status outputs decode registered state only, except o_count_top, which also decodes the i_compare_a_top input.
  assign o_rdata               = rdata;
  assign o_count_value         = count_value;
  assign o_count_floor         = (count_value == timer16_pkg::COUNT_FLOOR);
  assign o_count_top           = (count_value == top);
  assign o_waveform_mode_field = mode;
  assign o_capture_irq         = capture_flag & capture_irq_enable;
  assign o_overflow_irq        = overflow_flag & overflow_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);

  property p_write_priority;
    wr_count_low |=> count_value == {$past(holding), $past(i_bus.wdata)};
  endproperty
  a_write_priority: assert property (p_write_priority) else $error("count write lost");

  property p_stopped;
    (control_b.clock_source_field == 3'h0) && !wr_count_low |=> $stable(count_value);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped counter moved");

  property p_capture_copy;
    capture_event |=> (capture_value == $past(count_value)) && capture_flag;
  endproperty
  a_capture_copy: assert property (p_capture_copy) else $error("capture copy wrong");

  property p_flag_with_copy;
    $rose(capture_flag) |-> $past(capture_event);
  endproperty
  a_flag_with_copy: assert property (p_flag_with_copy) else $error("flag without copy");

  property p_low_read_holding;
    i_bus.rd && (i_bus.addr == timer16_pkg::ADDR_COUNT_VALUE_LOW) ##1
      i_bus.rd && (i_bus.addr == timer16_pkg::ADDR_COUNT_VALUE_HIGH)
      |=> o_rdata == $past(count_value[15:8], 2);
  endproperty
  a_low_read_holding: assert property (p_low_read_holding) else $error("high byte mismatch");

  property p_capture_read;
    i_bus.rd && (i_bus.addr == timer16_pkg::ADDR_CAPTURE_VALUE_LOW) |=> holding == $past(capture_value[15:8]);
  endproperty
  a_capture_read: assert property (p_capture_read) else $error("capture holding wrong");

  property p_capture_write_refused;
    i_bus.wr && (i_bus.addr == timer16_pkg::ADDR_CAPTURE_VALUE_LOW)
      && !timer16_pkg::uses_capture_top(mode) && !capture_event |=> $stable(capture_value);
  endproperty
  a_capture_write_refused: assert property (p_capture_write_refused) else $error("capture write taken");

  property p_flag_clear;
    i_bus.wr && (i_bus.addr == timer16_pkg::ADDR_FLAGS) && i_bus.wdata[timer16_pkg::FLAG_CAPTURE_BIT]
      && !capture_event |=> !capture_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("capture flag not cleared");

  property p_filter;
    $past(control_b.noise_filter_enable) && $changed(filtered) |-> $past(samples) == {4{filtered}};
  endproperty
  a_filter: assert property (p_filter) else $error("filter changed early");

  property p_capture_off;
    timer16_pkg::uses_capture_top(mode) && !wr_capture_low |=> $stable(capture_value) && !$rose(capture_flag);
  endproperty
  a_capture_off: assert property (p_capture_off) else $error("capture in capture-top mode");

  property p_holding_load;
    i_bus.wr && (i_bus.addr == timer16_pkg::ADDR_COUNT_VALUE_HIGH) |=> holding == $past(i_bus.wdata);
  endproperty
  a_holding_load: assert property (p_holding_load) else $error("holding not loaded");

  c_capture:  cover property (capture_event ##1 capture_flag);
  c_overflow: cover property ($rose(overflow_flag));
  c_reverse:  cover property ($rose(count_down) ##[1:600] $fell(count_down));
  c_write16:  cover property (i_bus.wr && (i_bus.addr == timer16_pkg::ADDR_COUNT_VALUE_HIGH) ##1 wr_count_low);

endmodule

// ==== src/timer16_pkg.sv ====
// What this block does
// - Sixteen-bit counter counting up or down.
// - Counter seen as high and low bytes.
// - Low byte access moves high byte via holding.
// - Each tick clears, increments or decrements.
// - Clock source zero stops the counter.
// - Counter readable and writable while stopped.
// - Software write beats count or clear.
// - Four-bit mode field sets count sequence.
// - Overflow flag set per mode, interrupt capable.
// - Floor output at zero; clear zeroes all.
// - Three-bit field selects the tick source.
// - Selected edge copies counter into capture.
// - Capture flag set with the copy.
// - Enabled flag interrupts; acknowledge clears it.
// - Writing one clears the capture flag.
// - Capture low read loads holding; high returns.
// - Capture writes only in capture-top modes.
// - Comparator replaces pin when select set.
// - Software clears flag after source switch.
// - Both triggers synchronised like external clock.
// - Filter needs four equal samples to change.
// - Capture path off in capture-top modes.
package timer16_pkg;

  localparam logic [3:0] ADDR_CONTROL_A          = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_B          = 4'h1;
  localparam logic [3:0] ADDR_COUNT_VALUE_LOW    = 4'h2;
  localparam logic [3:0] ADDR_COUNT_VALUE_HIGH   = 4'h3;
  localparam logic [3:0] ADDR_CAPTURE_VALUE_LOW  = 4'h4;
  localparam logic [3:0] ADDR_CAPTURE_VALUE_HIGH = 4'h5;
  localparam logic [3:0] ADDR_FLAGS              = 4'h6;
  localparam logic [3:0] ADDR_IRQ_ENABLE         = 4'h7;
  localparam logic [3:0] ADDR_COMPARATOR_CONTROL = 4'h8;

  localparam int FLAG_OVERFLOW_BIT   = 0;
  localparam int FLAG_CAPTURE_BIT    = 5;
  localparam int COMPARATOR_SEL_BIT  = 2;

  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [15:0] COUNT_FLOOR = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT    = 16'h00FF;
  localparam logic [15:0] TOP_9BIT    = 16'h01FF;
  localparam logic [15:0] TOP_10BIT   = 16'h03FF;
  localparam logic [15:0] COUNT_ONE   = 16'h0001;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic       noise_filter_enable;
    logic       rising_edge;
    logic       unused;
    logic [1:0] mode_high;
    logic [2:0] clock_source_field;
  } control_b_t;

  // Modes whose ceiling is the capture register.
  function automatic logic uses_capture_top(input logic [3:0] mode);
    return (mode == 4'h8) || (mode == 4'hA) || (mode == 4'hC) || (mode == 4'hE);
  endfunction

  // Modes that count up to the ceiling and back down.
  function automatic logic dual_slope(input logic [3:0] mode);
    return ((mode >= 4'h1) && (mode <= 4'h3)) || ((mode >= 4'h8) && (mode <= 4'hB));
  endfunction

  // Single-slope modes that flag overflow at the ceiling.
  function automatic logic overflow_at_top(input logic [3:0] mode);
    return ((mode >= 4'h5) && (mode <= 4'h7)) || (mode == 4'hE) || (mode == 4'hF);
  endfunction

  function automatic logic [15:0] mode_top(input logic [3:0]  mode,
                                           input logic [15:0] capture,
                                           input logic [15:0] compare_a);
    unique case (mode)
      4'h1, 4'h5:                      return TOP_8BIT;
      4'h2, 4'h6:                      return TOP_9BIT;
      4'h3, 4'h7:                      return TOP_10BIT;
      4'h8, 4'hA, 4'hC, 4'hE:          return capture;
      4'h4, 4'h9, 4'hB, 4'hF:          return compare_a;
      default:                         return COUNT_MAX;
    endcase
  endfunction

endpackage

// ==== sim/cpu_model.sv ====
module cpu_model (
  input  wire logic            i_clock,
  output timer16_pkg::bus_req_t o_bus,
  output logic                 o_rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  //////////////////////////////////////////////////////////////////////////////
  // The core issues one strobe per access and never interleaves another access.
  initial begin
    o_bus      = '0;
    o_rd_valid = 1'b0;
  end

  // Read data is due one cycle after the strobe edge, so the watcher needs this.
  always @(posedge i_clock) begin
    o_rd_valid <= o_bus.rd;
  end

  // One access, then the lines show inverted leftovers so stale values never match.
  task automatic access(input logic [3:0] a, input logic [7:0] d, input logic w);
    @(posedge i_clock);
    o_bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge i_clock);
    o_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
endmodule

// ==== sim/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  i_clock = 1'b0;
  logic                  i_rstn  = 1'b0;
  logic [1:0]            trig    = 2'b00;
  logic                  cap_ack = 1'b0;
  timer16_pkg::bus_req_t bus;
  logic                  rd_valid;
  logic [7:0]            rdata;
  logic [15:0]           count_value;
  logic                  count_floor;
  logic [3:0]            mode;
  logic                  cap_irq;
  logic                  ovf_irq;
  logic                  count_top;
  logic [3:0]            presc      = 4'h0;
  logic                  ext        = 1'b0;
  int                    n_mismatch = 0;
  int                    checks     = 0;
  logic [7:0]            expq[$];
  logic [31:0]           seed       = 32'h0000F61D;

  always #5 i_clock = ~i_clock;

  cpu_model u_cpu (.i_clock(i_clock), .o_bus(bus), .o_rd_valid(rd_valid));

  timer16_counter_input_capture u_dut (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_bus(bus), .o_rdata(rdata), .i_prescale_tick(presc),
    .i_external_clock_pin(ext), .i_capture_pin(trig[0]), .i_comparator_output(trig[1]),
    .i_compare_a_top(16'h00FF), .i_capture_irq_ack(cap_ack), .i_overflow_irq_ack(1'b0),
    .o_count_value(count_value), .o_count_floor(count_floor), .o_count_top(count_top), .o_waveform_mode_field(mode),
    .o_capture_irq(cap_irq), .o_overflow_irq(ovf_irq));

  //////////////////////////////////////////////////////////////////////////////
  // Shared helpers.
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    // A read answer that never arrived is a failure too.
    if (expq.size() != 0) begin
      n_mismatch++;
    end
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The expectation is queued before the strobe goes out.
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    expq.push_back(e);
    u_cpu.access(a, 8'h00, 1'b0);
  endtask

  // High byte goes first so the low write commits both halves.
  task automatic wr16(input logic [3:0] hi, input logic [15:0] v);
    u_cpu.access(hi, v[15:8], 1'b1);
    u_cpu.access(hi - 4'h1, v[7:0], 1'b1);
  endtask

  task automatic rd16(input logic [3:0] lo, input logic [15:0] e);
    rd_chk(lo, e[7:0]);
    rd_chk(lo + 4'h1, e[15:8]);
  endtask

  // The wait covers two sync stages, the filter and the edge detector.
  task automatic pulse(input int n, input logic [1:0] m);
    @(posedge i_clock) trig <= m;
    repeat (n) @(posedge i_clock);
    trig <= 2'b00;
    repeat (12) @(posedge i_clock);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_cpu.access(a, d, 1'b1);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // The watcher pairs each read answer with the oldest note.
  always @(posedge i_clock) begin
    if (rd_valid === 1'b1) compare({8'h00, rdata}, {8'h00, expq.pop_front()});
  end

  // A hang is cut short well past the few hundred cycles the tests need.
  initial begin
    #200us;
    n_mismatch++;
    final_report();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [15:0] v;
    repeat (8) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    #1 compare({15'h0000, count_floor}, 16'h0001);
    rd16(timer16_pkg::ADDR_COUNT_VALUE_LOW, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      v = 16'(xorshift());
      wr16(timer16_pkg::ADDR_COUNT_VALUE_HIGH, v);
      #1 compare(count_value, v);
      repeat (3) @(posedge i_clock);
      rd16(timer16_pkg::ADDR_COUNT_VALUE_LOW, v);
    end
    $display("test byte access done");
    wr(timer16_pkg::ADDR_CONTROL_B, 8'h18);
    #1 compare({12'h000, mode}, 16'h000C);
    wr(timer16_pkg::ADDR_CAPTURE_VALUE_HIGH, 8'h12);
    wr(timer16_pkg::ADDR_COUNT_VALUE_LOW, 8'h34);
    wr(timer16_pkg::ADDR_CAPTURE_VALUE_LOW, 8'h56);
    rd16(timer16_pkg::ADDR_COUNT_VALUE_LOW, 16'h1234);
    rd16(timer16_pkg::ADDR_CAPTURE_VALUE_LOW, 16'h1256);
    pulse(3, 2'b01);
    rd_chk(timer16_pkg::ADDR_FLAGS, 8'h00);
    wr(timer16_pkg::ADDR_CONTROL_B, 8'h00);
    wr16(timer16_pkg::ADDR_CAPTURE_VALUE_HIGH, 16'h9999);
    rd16(timer16_pkg::ADDR_CAPTURE_VALUE_LOW, 16'h1256);
    $display("test holding byte done");
    wr(timer16_pkg::ADDR_IRQ_ENABLE, 8'h20);
    wr16(timer16_pkg::ADDR_COUNT_VALUE_HIGH, 16'h4321);
    pulse(3, 2'b01);
    compare({15'h0000, cap_irq}, 16'h0001);
    rd16(timer16_pkg::ADDR_CAPTURE_VALUE_LOW, 16'h4321);
    wr(timer16_pkg::ADDR_FLAGS, 8'h20);
    #1 compare({15'h0000, cap_irq}, 16'h0000);
    wr(timer16_pkg::ADDR_CONTROL_B, 8'h40);
    wr(timer16_pkg::ADDR_FLAGS, 8'h20);
    wr16(timer16_pkg::ADDR_COUNT_VALUE_HIGH, 16'h0A0B);
    pulse(3, 2'b01);
    rd16(timer16_pkg::ADDR_CAPTURE_VALUE_LOW, 16'h0A0B);
    compare({15'h0000, cap_irq}, 16'h0001);
    @(posedge i_clock) cap_ack <= 1'b1;
    @(posedge i_clock) cap_ack <= 1'b0;
    #1 compare({15'h0000, cap_irq}, 16'h0000);
    $display("test capture pin done");
    wr(timer16_pkg::ADDR_COMPARATOR_CONTROL, 8'h04);
    wr(timer16_pkg::ADDR_FLAGS, 8'h20);
    wr16(timer16_pkg::ADDR_COUNT_VALUE_HIGH, 16'h0C0D);
    pulse(3, 2'b01);
    rd_chk(timer16_pkg::ADDR_FLAGS, 8'h00);
    pulse(3, 2'b10);
    rd16(timer16_pkg::ADDR_CAPTURE_VALUE_LOW, 16'h0C0D);
    wr(timer16_pkg::ADDR_COMPARATOR_CONTROL, 8'h00);
    wr(timer16_pkg::ADDR_CONTROL_B, 8'hC0);
    wr(timer16_pkg::ADDR_FLAGS, 8'h20);
    pulse(3, 2'b01);
    rd_chk(timer16_pkg::ADDR_FLAGS, 8'h00);
    pulse(6, 2'b01);
    rd_chk(timer16_pkg::ADDR_FLAGS, 8'h20);
    $display("test comparator and filter done");
    wr(timer16_pkg::ADDR_FLAGS, 8'h21);
    wr(timer16_pkg::ADDR_CONTROL_B, 8'h00);
    wr16(timer16_pkg::ADDR_COUNT_VALUE_HIGH, 16'hFFFD);
    wr(timer16_pkg::ADDR_CONTROL_B, 8'h01);
    #1 v = count_value;
    @(posedge i_clock);
    #1 compare(count_value, v + 16'h0001);
    repeat (4) @(posedge i_clock);
    rd_chk(timer16_pkg::ADDR_FLAGS, 8'h01);
    compare({15'h0000, ovf_irq}, 16'h0000);
    wr(timer16_pkg::ADDR_IRQ_ENABLE, 8'h21);
    #1 compare({15'h0000, ovf_irq}, 16'h0001);
    wr16(timer16_pkg::ADDR_COUNT_VALUE_HIGH, 16'h5000);
    #1 compare(count_value, 16'h5000);
    wr(timer16_pkg::ADDR_CONTROL_A, 8'h01);
    wr16(timer16_pkg::ADDR_COUNT_VALUE_HIGH, 16'h00FF);
    #1 compare({15'h0000, count_top}, 16'h0001);
    @(posedge i_clock);
    #1 compare(count_value, 16'h00FE);
    wr(timer16_pkg::ADDR_CONTROL_B, 8'h00);
    wr16(timer16_pkg::ADDR_COUNT_VALUE_HIGH, 16'h0000);
    #1 compare({15'h0000, count_floor}, 16'h0001);
    // One prescaler pulse and one external rising edge must each give exactly one tick.
    wr(timer16_pkg::ADDR_CONTROL_B, 8'h02);
    @(posedge i_clock) presc <= 4'h1;
    @(posedge i_clock) presc <= 4'h0;
    #1 compare(count_value, 16'h0001);
    wr(timer16_pkg::ADDR_CONTROL_B, 8'h07);
    @(posedge i_clock) ext <= 1'b1;
    repeat (4) @(posedge i_clock);
    #1 compare(count_value, 16'h0002);
    $display("test counting done");
    repeat (3) @(posedge i_clock);
    final_report();
  end
endmodule
